// [src/pbc_pkg.sv]
// Purpose: shared constants and carrier types of the base clock selector
// Assumes: 8-bit registers placed in the low byte of a 32-bit APB word
// Notes:   offsets are byte addresses, one aligned word per register
package pbc_pkg;

    localparam logic [7:0] PBC_OFS_CTRL = 8'h00;
    localparam logic [7:0] PBC_OFS_BW   = 8'h04;
    localparam logic [7:0] PBC_OFS_PROG = 8'h08;

    // pll_control_reg fields
    localparam int PBC_CTRL_IE   = 7;
    localparam int PBC_CTRL_FLAG = 6;
    localparam int PBC_CTRL_ON   = 5;
    localparam int PBC_CTRL_BCS  = 4;
    localparam logic [3:0] PBC_CTRL_LOW_ONES = 4'hF;

    // bandwidth_control_reg fields
    localparam int PBC_BW_AUTO = 7;
    localparam int PBC_BW_LOCK = 6;
    localparam int PBC_BW_ACQ  = 5;
    localparam int PBC_BW_XLD  = 4;

    // pll_program_reg fields and reset values
    localparam int PBC_PROG_MUL_LSB = 4;
    localparam int PBC_PROG_VRS_LSB = 0;
    localparam logic [3:0] PBC_MUL_RST = 4'h6;
    localparam logic [3:0] PBC_VRS_RST = 4'h6;
    localparam logic       PBC_ON_RST  = 1'b1;
    localparam logic [3:0] PBC_N_MIN   = 4'h1;

    typedef struct packed {
        logic ie;
        logic on;
        logic base_clock_select;
    } pbc_ctrl_s;

    typedef struct packed {
        logic [3:0] mul;
        logic [3:0] vrs;
    } pbc_prog_s;

    typedef struct packed {
        logic auto_bw;
        logic acq;
    } pbc_bw_s;

endpackage : pbc_pkg

// [src/pbc_clock_switch.sv]
// Purpose: glitch-free switch between crystal and vco clock, then divide by two
// Assumes: want_x and want_v are levels from flip-flops, never both high
// Notes:   each enable passes three flops in its own source clock domain
`timescale 1ns/1ps
`default_nettype none
module pbc_clock_switch
    import pbc_pkg::*;
(
    input  wire logic arst_n,
    input  wire logic crystal_clock,
    input  wire logic vco_clock,
    input  wire logic want_x,
    input  wire logic want_v,
    output logic      base_clock_out
);

    logic x_s1_reg;
    logic x_s2_reg;
    logic x_en_reg;
    logic v_s1_reg;
    logic v_s2_reg;
    logic v_en_reg;
    wire  x_req;
    wire  v_req;
    wire  gated_clock;

    // a source may start only once the other one has been shut off
    assign x_req = want_x & ~v_en_reg;  // [R23]
    assign v_req = want_v & ~x_en_reg;  // [R23]

    always_ff @(posedge crystal_clock or negedge arst_n) begin
        if (!arst_n) begin
            x_s1_reg <= 1'b0;
            x_s2_reg <= 1'b0;
        end else begin
            x_s1_reg <= x_req;  // [R1]
            x_s2_reg <= x_s1_reg;
        end
    end

    // enable changes on the falling edge so the and-gate never cuts a high phase
    always_ff @(negedge crystal_clock or negedge arst_n) begin
        if (!arst_n) begin
            x_en_reg <= 1'b0;
        end else begin
            x_en_reg <= x_s2_reg;  // [R1]
        end
    end

    always_ff @(posedge vco_clock or negedge arst_n) begin
        if (!arst_n) begin
            v_s1_reg <= 1'b0;
            v_s2_reg <= 1'b0;
        end else begin
            v_s1_reg <= v_req;  // [R1]
            v_s2_reg <= v_s1_reg;
        end
    end

    always_ff @(negedge vco_clock or negedge arst_n) begin
        if (!arst_n) begin
            v_en_reg <= 1'b0;
        end else begin
            v_en_reg <= v_s2_reg;  // [R1]
        end
    end

    // both enables low in the gap: no edge reaches the divider
    assign gated_clock = (crystal_clock & x_en_reg) | (vco_clock & v_en_reg);  // [R2]

    // divide by two fixes any source duty cycle to an even one
    always_ff @(posedge gated_clock or negedge arst_n) begin
        if (!arst_n) begin
            base_clock_out <= 1'b0;
        end else begin
            base_clock_out <= ~base_clock_out;  // [R3] [R4] [R5]
        end
    end

endmodule : pbc_clock_switch
`default_nettype wire

// [src/pbc_selector.sv]
// Purpose: register file, interlocks and lock-change event of the base clock selector
// Assumes: lock_in, acq_in, stop_in, osc_enable_in are synchronous to mclk
// Notes:   APB answers with one wait-free access cycle; outputs are all flops
//
// Behaviour
// [R1] on a source change, wait up to three cycles of each source clock
// [R2] base clock holds still, no edges, while the switch is in progress
// [R3] switch output is divided by two to give the base clock
// [R4] bus clock is one fourth of the selected source clock
// [R5] base clock has 50% duty at twice the bus rate
// [R6] select bit set picks vco clock, clear picks crystal clock
// [R7] selecting vco is refused while pll power is off
// [R8] clearing pll power is refused while vco is selected
// [R9] one write cannot change both pll power and clock select
// [R10] multiplier zero behaves as multiplier one
// [R11] range zero disables the pll and blocks vco selection
// [R12] range zero forces the crystal clock as source
// [R13] software puts multiplier in upper nibble, range in lower nibble
// [R14] oscillator enable input gates both crystal oscillator and pll
// [R15] interrupt output is driven from the lock event logic
// [R16] with enable set, each lock toggle sets flag and raises interrupt
// [R17] with automatic bandwidth off, interrupt enable ignores writes, reads zero
// [R18] reset clears the interrupt enable bit
// [R19] any control register read clears the lock-change flag; reset clears it; here only a read that returned the flag set clears it
// [R20] reset and stop mode clear the clock select bit
// [R21] multiplier and range writes are ignored while pll power is on
// [R22] reset sets the pll power bit
// [R23] select change is synchronised into each source domain, no glitch
`timescale 1ns/1ps
`default_nettype none
module pbc_selector
    import pbc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        crystal_clock,
    input  wire logic        vco_clock,
    input  wire logic        osc_enable_in,
    input  wire logic        stop_in,
    input  wire logic        lock_in,
    input  wire logic        acq_in,
    output logic             base_clock_out,
    output logic             clock_irq_out,
    output logic             osc_run_out,
    output logic             pll_run_out,
    output logic      [3:0]  feedback_n_out,
    output logic      [3:0]  range_l_out,
    output logic             tracking_out
);

    pbc_ctrl_s  ctrl_reg;
    pbc_ctrl_s  ctrl_next;
    pbc_prog_s  prog_reg;
    pbc_prog_s  prog_next;
    pbc_bw_s    bw_reg;
    pbc_bw_s    bw_next;
    logic       flag_reg;
    logic       flag_next;
    logic       flag_seen_reg;
    logic       lock_prev_reg;
    logic       want_x_reg;
    logic       want_v_reg;
    logic [31:0] prdata_reg;
    logic       pready_reg;
    logic       pslverr_reg;
    logic       irq_reg;
    logic       osc_run_reg;
    logic       pll_run_reg;
    logic [3:0] feedback_n_reg;
    logic [3:0] range_l_reg;
    logic       tracking_reg;
    logic       osc_en_seen_reg;

    // bus decode
    wire        setup    = psel & ~penable;
    wire        acc      = psel & penable & pready_reg;
    wire        hit_ctrl = (paddr == PBC_OFS_CTRL);
    wire        hit_bw   = (paddr == PBC_OFS_BW);
    wire        hit_prog = (paddr == PBC_OFS_PROG);
    wire        unmapped = ~(hit_ctrl | hit_bw | hit_prog);
    wire        wr_ctrl  = acc & pwrite & hit_ctrl;
    wire        wr_bw    = acc & pwrite & hit_bw;
    wire        wr_prog  = acc & pwrite & hit_prog;
    wire        rd_ctrl  = acc & ~pwrite & hit_ctrl;

    // control write interlocks
    wire        vrs_zero = (prog_reg.vrs == 4'h0);
    wire        req_on   = pwdata[PBC_CTRL_ON];
    wire        req_bcs  = pwdata[PBC_CTRL_BCS];
    wire        on_chg   = wr_ctrl & (req_on != ctrl_reg.on);
    wire        bcs_chg  = wr_ctrl & (req_bcs != ctrl_reg.base_clock_select);
    // power may not drop under a selected vco, nor move with the select
    wire        on_ok    = on_chg & ~bcs_chg & ~ctrl_reg.base_clock_select;  // [R8] [R9]
    wire        vco_ok   = ctrl_reg.on & ~vrs_zero;  // [R7] [R11]
    wire        bcs_ok   = bcs_chg & ~on_chg & (~req_bcs | vco_ok);  // [R7] [R9]
    wire        bcs_kill = stop_in | vrs_zero;  // [R12] [R20]

    // lock event
    wire        toggle   = bw_reg.auto_bw & (lock_in ^ lock_prev_reg);  // [R16]
    wire        flag_clr = rd_ctrl & flag_seen_reg;  // [R19]
    wire        gate_run = osc_enable_in;  // [R14]

    // read data
    wire [7:0]  rd_ctrl_v = {ctrl_reg.ie & bw_reg.auto_bw,  // [R17]
                             flag_reg & bw_reg.auto_bw,
                             ctrl_reg.on,
                             ctrl_reg.base_clock_select,
                             PBC_CTRL_LOW_ONES};
    wire        acq_view  = bw_reg.auto_bw ? acq_in : bw_reg.acq;
    wire [7:0]  rd_bw_v   = {bw_reg.auto_bw,
                             lock_prev_reg & bw_reg.auto_bw,
                             acq_view,
                             1'b0,
                             4'h0};
    wire [7:0]  rd_mux    = hit_ctrl ? rd_ctrl_v :
                            hit_bw   ? rd_bw_v :
                            hit_prog ? {prog_reg.mul, prog_reg.vrs} : 8'h00;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (on_ok) begin
            ctrl_next.on = req_on;  // [R8]
        end
        if (bcs_kill) begin
            ctrl_next.base_clock_select = 1'b0;  // [R12] [R20]
        end else if (bcs_ok) begin
            ctrl_next.base_clock_select = req_bcs;  // [R6]
        end
        if (wr_ctrl & bw_reg.auto_bw) begin
            ctrl_next.ie = pwdata[PBC_CTRL_IE];  // [R17]
        end
    end

    always_comb begin
        prog_next = prog_reg;
        // the divider must not move under a running loop
        if (wr_prog & ~ctrl_reg.on) begin  // [R21]
            prog_next.mul = pwdata[PBC_PROG_MUL_LSB +: 4];
            prog_next.vrs = pwdata[PBC_PROG_VRS_LSB +: 4];
        end
    end

    always_comb begin
        bw_next = bw_reg;
        if (wr_bw) begin
            bw_next.auto_bw = pwdata[PBC_BW_AUTO];
            // manual value stays parked while automatic mode runs
            if (~bw_reg.auto_bw) begin
                bw_next.acq = pwdata[PBC_BW_ACQ];
            end
        end
    end

    // a new toggle beats a clearing read in the same cycle
    assign flag_next = toggle ? 1'b1 :
                       (flag_clr | ~bw_reg.auto_bw) ? 1'b0 : flag_reg;  // [R16] [R19]

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg      <= '{ie: 1'b0, on: PBC_ON_RST, base_clock_select: 1'b0};  // [R18] [R20] [R22]
            prog_reg      <= '{mul: PBC_MUL_RST, vrs: PBC_VRS_RST};
            bw_reg        <= '{auto_bw: 1'b0, acq: 1'b0};
            flag_reg      <= 1'b0;  // [R19]
            lock_prev_reg <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            prog_reg      <= prog_next;
            bw_reg        <= bw_next;
            flag_reg      <= flag_next;
            lock_prev_reg <= lock_in;
        end
    end

    // flag is cleared only if the read actually returned it set
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            flag_seen_reg <= 1'b0;
        end else begin
            pready_reg    <= setup;
            pslverr_reg   <= setup & unmapped;
            if (setup & ~pwrite) begin
                prdata_reg    <= {24'h00_0000, rd_mux};
                flag_seen_reg <= flag_reg & hit_ctrl;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg        <= 1'b0;
            osc_run_reg    <= 1'b0;
            pll_run_reg    <= 1'b0;
            feedback_n_reg <= PBC_N_MIN;
            range_l_reg    <= 4'h0;
            tracking_reg   <= 1'b0;
            want_x_reg     <= 1'b0;
            want_v_reg     <= 1'b0;
        end else begin
            irq_reg        <= flag_reg & ctrl_reg.ie & bw_reg.auto_bw;  // [R15] [R16]
            osc_run_reg    <= gate_run;  // [R14]
            pll_run_reg    <= gate_run & ctrl_reg.on & ~vrs_zero;  // [R11] [R14]
            feedback_n_reg <= (prog_reg.mul == 4'h0) ? PBC_N_MIN : prog_reg.mul;  // [R10]
            range_l_reg    <= prog_reg.vrs;
            tracking_reg   <= acq_view;
            want_x_reg     <= gate_run & ~ctrl_reg.base_clock_select;  // [R6] [R14]
            want_v_reg     <= gate_run & ctrl_reg.base_clock_select;  // [R6] [R14]
        end
    end

    pbc_clock_switch u_switch (
        .arst_n         (arst_n),
        .crystal_clock  (crystal_clock),
        .vco_clock      (vco_clock),
        .want_x         (want_x_reg),
        .want_v         (want_v_reg),
        .base_clock_out (base_clock_out)
    );

    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign clock_irq_out  = irq_reg;
    assign osc_run_out    = osc_run_reg;
    assign pll_run_out    = pll_run_reg;
    assign feedback_n_out = feedback_n_reg;
    assign range_l_out    = range_l_reg;
    assign tracking_out   = tracking_reg;

    sequence s_toggle_armed;
        toggle && ctrl_reg.ie && bw_reg.auto_bw && !acc;
    endsequence

    sequence s_vco_request;
        wr_ctrl && req_bcs && !ctrl_reg.base_clock_select && !ctrl_reg.on && !on_chg;
    endsequence

    chk_bcs_needs_on: assert property ( // [R7]
        @(posedge mclk) disable iff (!arst_n)
        ctrl_reg.base_clock_select |-> ctrl_reg.on && !vrs_zero)
        else $error("vco selected without pll power or range");

    chk_vco_refused: assert property ( // [R7]
        @(posedge mclk) disable iff (!arst_n)
        s_vco_request |=> !ctrl_reg.base_clock_select)
        else $error("vco select accepted while pll off");

    chk_power_held: assert property ( // [R8]
        @(posedge mclk) disable iff (!arst_n)
        ctrl_reg.base_clock_select && wr_ctrl && !req_on |=> ctrl_reg.on)
        else $error("pll power cleared under selected vco");

    chk_no_dual_change: assert property ( // [R9]
        @(posedge mclk) disable iff (!arst_n)
        on_chg && bcs_chg && !bcs_kill |=> $stable({ctrl_reg.on, ctrl_reg.base_clock_select}))
        else $error("power and select changed by one write");

    chk_mul_zero: assert property ( // [R10]
        @(posedge mclk) disable iff (!arst_n)
        prog_reg.mul == 4'h0 |=> feedback_n_out == 4'h1)
        else $error("multiplier zero not treated as one");

    chk_range_zero: assert property ( // [R12]
        @(posedge mclk) disable iff (!arst_n)
        vrs_zero |=> !ctrl_reg.base_clock_select ##1 !want_v_reg && !pll_run_out)
        else $error("range zero did not force crystal");

    chk_irq_raise: assert property ( // [R16]
        @(posedge mclk) disable iff (!arst_n)
        s_toggle_armed |=> flag_reg ##1 clock_irq_out)
        else $error("lock toggle did not raise interrupt");

    chk_ie_manual: assert property ( // [R17]
        @(posedge mclk) disable iff (!arst_n)
        !bw_reg.auto_bw && wr_ctrl |=> $stable(ctrl_reg.ie))
        else $error("interrupt enable written in manual mode");

    chk_flag_read_clear: assert property ( // [R19]
        @(posedge mclk) disable iff (!arst_n)
        flag_clr && !toggle |=> !flag_reg)
        else $error("control read did not clear flag");

    chk_stop_clears: assert property ( // [R20]
        @(posedge mclk) disable iff (!arst_n)
        stop_in |=> !ctrl_reg.base_clock_select ##1 want_x_reg == osc_en_seen_reg)
        else $error("stop did not return to crystal");

    chk_prog_locked: assert property ( // [R21]
        @(posedge mclk) disable iff (!arst_n)
        wr_prog && ctrl_reg.on |=> $stable(prog_reg))
        else $error("program register written while pll on");

    // gate level one cycle late, lined up with want_x_reg
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            osc_en_seen_reg <= 1'b0;
        end else begin
            osc_en_seen_reg <= osc_enable_in;
        end
    end

endmodule : pbc_selector
`default_nettype wire

// [dv/pbc_src_model.sv]
// Purpose: far-side model: crystal and vco sources plus lock detector
// Assumes: run inputs come from the selector's osc_run_out and pll_run_out
// Notes:   a stopped source sits at 0, it never shows a stale phase
`timescale 1ns/1ps
`default_nettype none
module pbc_src_model
    import pbc_pkg::*;
#(
    parameter int XTAL_HALF = 35,
    parameter int VCO_HALF  = 15
)
(
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic osc_run,
    input  wire logic pll_run,
    input  wire logic lock_flip,
    output logic      crystal_clock,
    output logic      vco_clock,
    output logic      lock_in,
    output logic      acq_in
);
    logic lock_reg;

    initial crystal_clock = 1'b0;
    initial vco_clock = 1'b0;

    // halves chosen unrelated to mclk, so every crossing is exercised
    always begin
        #(XTAL_HALF);
        crystal_clock = osc_run ? ~crystal_clock : 1'b0;
    end

    always begin
        #(VCO_HALF);
        vco_clock = pll_run ? ~vco_clock : 1'b0;
    end

    // lock detector output is synchronous to mclk
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lock_reg <= 1'b0;
        end else if (lock_flip) begin
            lock_reg <= ~lock_reg;
        end
    end

    assign lock_in = lock_reg;
    assign acq_in  = lock_reg;
endmodule : pbc_src_model
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench for the base clock selector
// Assumes: apb answers without wait states, low byte carries the register
// Notes:   clock periods are measured in ns against the model's halves
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pbc_pkg::*;
;
    localparam int XH = 35;
    localparam int VH = 15;

    logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic        crystal_clock, vco_clock, osc_enable_in, stop_in, lock_in;
    logic        acq_in, base_clock_out, clock_irq_out, osc_run_out, pll_run_out;
    logic        tracking_out, lock_flip, err_v;
    logic [3:0]  feedback_n_out, range_l_out;
    int          n_errors, check_count;

    pbc_selector dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crystal_clock(crystal_clock),
        .vco_clock(vco_clock), .osc_enable_in(osc_enable_in), .stop_in(stop_in),
        .lock_in(lock_in), .acq_in(acq_in), .base_clock_out(base_clock_out),
        .clock_irq_out(clock_irq_out), .osc_run_out(osc_run_out),
        .pll_run_out(pll_run_out), .feedback_n_out(feedback_n_out),
        .range_l_out(range_l_out), .tracking_out(tracking_out));

    pbc_src_model #(.XTAL_HALF(XH), .VCO_HALF(VH)) src (.mclk(mclk), .arst_n(arst_n),
        .osc_run(osc_run_out), .pll_run(pll_run_out), .lock_flip(lock_flip),
        .crystal_clock(crystal_clock), .vco_clock(vco_clock), .lock_in(lock_in),
        .acq_in(acq_in));

    always #50 mclk = ~mclk;

    task automatic end_of_test();
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask : wr

    task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(name, rd_v, {24'h000000, exp});
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    // one full period and its high phase of the base clock
    task automatic base_period(input string name, input int half);
        time t0, t1, t2;
        cyc(30);
        @(posedge base_clock_out) t0 = $time;
        @(negedge base_clock_out) t1 = $time;
        @(posedge base_clock_out) t2 = $time;
        check(name, 32'(t2 - t0), 32'(4 * half));
        check(name, 32'(t1 - t0), 32'(2 * half));
    endtask : base_period

    task automatic t_reset();
        rd("ctrl rst", PBC_OFS_CTRL, 8'h2F);
        rd("bw rst", PBC_OFS_BW, 8'h00);
        wr(PBC_OFS_PROG, 8'h11);
        rd("prog locked", PBC_OFS_PROG, 8'h66);
        check("fb rst", {28'h0, feedback_n_out}, 32'h6);
        base_period("xtal rst", XH);
    endtask : t_reset

    task automatic t_select();
        wr(PBC_OFS_CTRL, 8'h10);
        rd("both change", PBC_OFS_CTRL, 8'h2F);
        wr(PBC_OFS_CTRL, 8'h30);
        rd("bcs set", PBC_OFS_CTRL, 8'h3F);
        base_period("vco", VH);
        wr(PBC_OFS_CTRL, 8'h10);
        rd("off refused", PBC_OFS_CTRL, 8'h3F);
        @(posedge mclk) stop_in <= 1'b1;
        @(posedge mclk) stop_in <= 1'b0;
        rd("stop", PBC_OFS_CTRL, 8'h2F);
        base_period("xtal back", XH);
    endtask : t_select

    task automatic t_program();
        wr(PBC_OFS_CTRL, 8'h00);
        rd("pll off", PBC_OFS_CTRL, 8'h0F);
        wr(PBC_OFS_PROG, 8'h00);
        rd("prog 0", PBC_OFS_PROG, 8'h00);
        cyc(2);
        check("fb zero", {28'h0, feedback_n_out}, 32'h1);
        wr(PBC_OFS_CTRL, 8'h10);
        rd("bcs pll off", PBC_OFS_CTRL, 8'h0F);
        wr(PBC_OFS_CTRL, 8'h20);
        wr(PBC_OFS_CTRL, 8'h30);
        rd("range 0", PBC_OFS_CTRL, 8'h2F);
        check("pll idle", {31'h0, pll_run_out}, 32'h0);
        wr(PBC_OFS_CTRL, 8'h00);
        wr(PBC_OFS_PROG, 8'h85);
        rd("prog 85", PBC_OFS_PROG, 8'h85);
        cyc(2);
        check("fb 8", {28'h0, feedback_n_out}, 32'h8);
        check("range 5", {28'h0, range_l_out}, 32'h5);
        wr(PBC_OFS_CTRL, 8'h20);
        cyc(2);
        check("pll run", {31'h0, pll_run_out}, 32'h1);
        @(posedge mclk) osc_enable_in <= 1'b0;
        cyc(3);
        check("osc gated", {30'h0, osc_run_out, pll_run_out}, 32'h0);
        @(posedge mclk) osc_enable_in <= 1'b1;
        cyc(3);
        check("osc back", {30'h0, osc_run_out, pll_run_out}, 32'h3);
    endtask : t_program

    task automatic t_lock();
        wr(PBC_OFS_CTRL, 8'hA0);
        rd("ie manual", PBC_OFS_CTRL, 8'h2F);
        @(posedge mclk) lock_flip <= 1'b1;
        @(posedge mclk) lock_flip <= 1'b0;
        cyc(4);
        check("irq manual", {31'h0, clock_irq_out}, 32'h0);
        rd("bw manual", PBC_OFS_BW, 8'h00);
        // lock is high now, so a zero here shows the stored manual bit
        check("track manual", {31'h0, tracking_out}, 32'h0);
        wr(PBC_OFS_BW, 8'h20);
        rd("acq manual", PBC_OFS_BW, 8'h20);
        check("track set", {31'h0, tracking_out}, 32'h1);
        // stored bit is cleared by this write, auto must show the detector
        wr(PBC_OFS_BW, 8'h80);
        cyc(2);
        check("track auto", {31'h0, tracking_out}, 32'h1);
        apb(1'b0, PBC_OFS_CTRL, 32'h0);
        wr(PBC_OFS_CTRL, 8'hA0);
        rd("ie auto", PBC_OFS_CTRL, 8'hAF);
        @(posedge mclk) lock_flip <= 1'b1;
        @(posedge mclk) lock_flip <= 1'b0;
        cyc(4);
        check("irq raised", {31'h0, clock_irq_out}, 32'h1);
        rd("flag set", PBC_OFS_CTRL, 8'hEF);
        cyc(3);
        check("irq cleared", {31'h0, clock_irq_out}, 32'h0);
        rd("flag read clr", PBC_OFS_CTRL, 8'hAF);
        rd("bw auto", PBC_OFS_BW, 8'h80);
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped", {err_v, rd_v[30:0]}, 32'h80000000);
        apb(1'b1, 8'h0C, 32'h000000FF);
        check("unmapped wr", {31'h0, err_v}, 32'h1);
    endtask : t_lock

    // reset in mid-run with vco selected, ie set and program moved
    task automatic t_rearm();
        wr(PBC_OFS_CTRL, 8'hB0);
        rd("vco again", PBC_OFS_CTRL, 8'hBF);
        @(posedge mclk) arst_n <= 1'b0;
        cyc(4);
        @(posedge mclk) arst_n <= 1'b1;
        rd("ctrl rearm", PBC_OFS_CTRL, 8'h2F);
        rd("prog rearm", PBC_OFS_PROG, 8'h66);
        wr(PBC_OFS_BW, 8'h80);
        rd("ie rearm", PBC_OFS_CTRL, 8'h2F);
        base_period("xtal rearm", XH);
    endtask : t_rearm

    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        {psel, penable, pwrite, stop_in, lock_flip} = '0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        osc_enable_in = 1'b1;
        n_errors = 0;
        check_count = 0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_select();
        t_program();
        t_lock();
        t_rearm();
        end_of_test();
    end

    // whole run is a few hundred cycles, 2 ms leaves ample margin
    initial begin
        #2000000;
        n_errors++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
